//--- inc/umtc_consts.svh
// offsets, field positions, select codes and timing counts for the transfer control block
`ifndef UMTC_CONSTS_SVH
`define UMTC_CONSTS_SVH
`define UMTC_OFS_CTRL 6'h00
`define UMTC_OFS_RDREQ 6'h04
`define UMTC_OFS_RDVAL 6'h08
`define UMTC_OFS_INT_STAT 6'h0C
`define UMTC_OFS_INT_EN 6'h10
`define UMTC_OFS_INT_CLR 6'h14
`define UMTC_BIT_WR_EN 0
`define UMTC_BIT_WR_ABORT 1
`define UMTC_BIT_WR_RESET 2
`define UMTC_BIT_RD_EN 4
`define UMTC_BIT_RD_ABORT 5
`define UMTC_BIT_RD_RESET 6
`define UMTC_BIT_REQ 31
`define UMTC_BIT_REQ_CLR 30
`define UMTC_ADR_LO 2
`define UMTC_ADR_HI 7
`define UMTC_SEL_WR_ADDR 6'h12
`define UMTC_SEL_RD_ADDR 6'h16
`define UMTC_SEL_TOUT 6'h22
`define UMTC_INT_RD_DONE 0
`define UMTC_INT_WR_DONE 1
`define UMTC_INT_REG_RD 2
`define UMTC_RESET_CYCLES 4'h4
`define UMTC_READ_LATENCY 2'h2
`endif

//--- inc/umtc_pkg.sv
// types for the transfer control block
package umtc_pkg;
    typedef enum logic [1:0] {
        UMTC_IDLE = 2'b00,
        UMTC_WAIT = 2'b01,
        UMTC_DONE = 2'b10
    } umtc_rd_state_type;
endpackage

//--- core/umtc_dir_ctrl.sv
// per-direction enable, abort and self-clearing block reset
`include "umtc_consts.svh"
module umtc_dir_ctrl
    import umtc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic set_enable,
    input wire logic abort_wr,
    input wire logic reset_wr,
    input wire logic xfer_done,
    output logic enable_reg,
    output logic reset_busy_reg,
    output logic abort_pulse_reg,
    output logic init_pulse_reg,
    output logic done_event
);
    logic [3:0] rst_cnt_reg;

    // block reset holds a few cycles so the far logic settles before release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rst_cnt_reg <= 4'h0;
            reset_busy_reg <= 1'b0;
            init_pulse_reg <= 1'b0;
        end else begin
            init_pulse_reg <= 1'b0;
            if (reset_wr && !reset_busy_reg) begin
                rst_cnt_reg <= `UMTC_RESET_CYCLES;
                reset_busy_reg <= 1'b1;
                init_pulse_reg <= 1'b1;
            end else if (reset_busy_reg) begin
                if (rst_cnt_reg == 4'h1) begin
                    reset_busy_reg <= 1'b0;
                end
                rst_cnt_reg <= rst_cnt_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            abort_pulse_reg <= 1'b0;
        end else begin
            abort_pulse_reg <= abort_wr;
        end
    end

    assign done_event = enable_reg && xfer_done && !abort_wr;

    // writing zero never clears; only done, abort or block reset do
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_reg <= 1'b0;
        end else if (abort_wr || reset_wr || reset_busy_reg) begin
            enable_reg <= 1'b0;
        end else if (xfer_done && enable_reg) begin
            enable_reg <= 1'b0;
        end else if (set_enable) begin
            enable_reg <= 1'b1;
        end
    end

    property p_done_clears;
        @(posedge ref_clk) disable iff (rst)
        (enable_reg && xfer_done) |=> !enable_reg;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("enable kept after done");

    property p_abort_clears;
        @(posedge ref_clk) disable iff (rst)
        abort_wr |=> !enable_reg && abort_pulse_reg;
    endproperty
    a_abort_clears: assert property (p_abort_clears) else $error("abort left enable set");

    property p_reset_len;
        @(posedge ref_clk) disable iff (rst)
        (reset_wr && !reset_busy_reg) |=> reset_busy_reg [*4] ##1 !reset_busy_reg;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset busy length wrong");

    property p_no_enable_in_reset;
        @(posedge ref_clk) disable iff (rst)
        reset_busy_reg |=> !enable_reg;
    endproperty
    a_no_enable_in_reset: assert property (p_no_enable_in_reset) else $error("enable during reset");
endmodule

//--- core/umtc_top.sv
// master transfer control registers, register read request and interrupts
//
// Local design decisions: the placing of the registers and the strobed register port.
`include "umtc_consts.svh"
//
// Function
// - read reset bit initializes master-read logic; endpoint fifos untouched
// - read reset self-clears; software waits for zero before next read transfer
// - read abort stops read transfer and clears read enable
// - abort is complete once the enable reads zero
// - each enable clears itself when that transfer completes
// - writing zero to an enable does not stop a transfer
// - write reset initializes master-write logic and self-clears
// - write abort stops write transfer and clears write enable
// - read request fetches selected register, then clears and flags completion
// - request clear cancels pending read, clears request, self-clears
module umtc_top
    import umtc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rd_xfer_done,
    input wire logic wr_xfer_done,
    input wire logic [31:0] wr_addr_value,
    input wire logic [31:0] rd_addr_value,
    input wire logic [31:0] tout_value,
    output logic read_dir_enable,
    output logic write_dir_enable,
    output logic read_dir_abort,
    output logic write_dir_abort,
    output logic read_dir_init,
    output logic write_dir_init,
    output logic irq
);
    logic wr_ctrl;
    logic wr_req;
    logic wr_iclr;
    logic rd_en_q;
    logic wr_en_q;
    logic rd_busy;
    logic wr_busy;
    logic rd_abort_q;
    logic wr_abort_q;
    logic rd_init_q;
    logic wr_init_q;
    logic rd_done_ev;
    logic wr_done_ev;
    logic req_reg;
    logic req_clr_reg;
    logic [5:0] sel_reg;
    logic [31:0] rdval_reg;
    logic [1:0] lat_reg;
    logic [2:0] int_stat_reg;
    logic [2:0] int_en_reg;
    logic [2:0] int_set;
    logic [31:0] rdata_next;
    logic [31:0] fetch_value;
    logic reg_rd_done;
    umtc_rd_state_type rd_state_reg;

    assign wr_ctrl = reg_wr && (reg_addr == `UMTC_OFS_CTRL);
    assign wr_req = reg_wr && (reg_addr == `UMTC_OFS_RDREQ);
    assign wr_iclr = reg_wr && (reg_addr == `UMTC_OFS_INT_CLR);

    umtc_dir_ctrl u_rd (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_enable(wr_ctrl && reg_wdata[`UMTC_BIT_RD_EN]),
        .abort_wr(wr_ctrl && reg_wdata[`UMTC_BIT_RD_ABORT]),
        .reset_wr(wr_ctrl && reg_wdata[`UMTC_BIT_RD_RESET]),
        .xfer_done(rd_xfer_done),
        .enable_reg(rd_en_q),
        .reset_busy_reg(rd_busy),
        .abort_pulse_reg(rd_abort_q),
        .init_pulse_reg(rd_init_q),
        .done_event(rd_done_ev)
    );

    umtc_dir_ctrl u_wr (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_enable(wr_ctrl && reg_wdata[`UMTC_BIT_WR_EN]),
        .abort_wr(wr_ctrl && reg_wdata[`UMTC_BIT_WR_ABORT]),
        .reset_wr(wr_ctrl && reg_wdata[`UMTC_BIT_WR_RESET]),
        .xfer_done(wr_xfer_done),
        .enable_reg(wr_en_q),
        .reset_busy_reg(wr_busy),
        .abort_pulse_reg(wr_abort_q),
        .init_pulse_reg(wr_init_q),
        .done_event(wr_done_ev)
    );

    // outputs straight from flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            read_dir_enable <= 1'b0;
            write_dir_enable <= 1'b0;
            read_dir_abort <= 1'b0;
            write_dir_abort <= 1'b0;
            read_dir_init <= 1'b0;
            write_dir_init <= 1'b0;
        end else begin
            read_dir_enable <= rd_en_q;
            write_dir_enable <= wr_en_q;
            read_dir_abort <= rd_abort_q;
            write_dir_abort <= wr_abort_q;
            read_dir_init <= rd_init_q || rd_busy;
            write_dir_init <= wr_init_q || wr_busy;
        end
    end

    // unknown select codes fetch zero rather than stale data
    always_comb begin
        unique case (sel_reg)
            `UMTC_SEL_WR_ADDR: fetch_value = wr_addr_value;
            `UMTC_SEL_RD_ADDR: fetch_value = rd_addr_value;
            `UMTC_SEL_TOUT: fetch_value = tout_value;
            default: fetch_value = 32'h00000000;
        endcase
    end

    // internal fetch takes a fixed latency to model the register path
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_state_reg <= UMTC_IDLE;
            req_reg <= 1'b0;
            lat_reg <= 2'h0;
            rdval_reg <= 32'h00000000;
        end else if (req_clr_reg) begin
            rd_state_reg <= UMTC_IDLE;
            req_reg <= 1'b0;
        end else begin
            unique case (rd_state_reg)
                UMTC_IDLE: begin
                    if (wr_req && reg_wdata[`UMTC_BIT_REQ] && !reg_wdata[`UMTC_BIT_REQ_CLR]) begin
                        req_reg <= 1'b1;
                        lat_reg <= `UMTC_READ_LATENCY;
                        rd_state_reg <= UMTC_WAIT;
                    end
                end
                UMTC_WAIT: begin
                    lat_reg <= lat_reg - 2'h1;
                    if (lat_reg == 2'h1) begin
                        rd_state_reg <= UMTC_DONE;
                    end
                end
                UMTC_DONE: begin
                    rdval_reg <= fetch_value;
                    req_reg <= 1'b0;
                    rd_state_reg <= UMTC_IDLE;
                end
                default: rd_state_reg <= UMTC_IDLE;
            endcase
        end
    end

    assign reg_rd_done = (rd_state_reg == UMTC_DONE) && !req_clr_reg;

    // clear bit is visible for one cycle, then drops by itself
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_clr_reg <= 1'b0;
        end else begin
            req_clr_reg <= wr_req && reg_wdata[`UMTC_BIT_REQ_CLR];
        end
    end

    // address field ignored while a fetch is pending
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_reg <= 6'h00;
        end else if (wr_req && rd_state_reg == UMTC_IDLE) begin
            sel_reg <= reg_wdata[`UMTC_ADR_HI:`UMTC_ADR_LO];
        end
    end

    assign int_set = {reg_rd_done, wr_done_ev, rd_done_ev};

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_stat_reg <= 3'h0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~(wr_iclr ? reg_wdata[2:0] : 3'h0)) | int_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_en_reg <= 3'h0;
        end else if (reg_wr && reg_addr == `UMTC_OFS_INT_EN) begin
            int_en_reg <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((int_stat_reg | int_set) & int_en_reg);
        end
    end

    // abort bits and the clear register always read zero
    always_comb begin
        rdata_next = 32'h00000000;
        unique case (reg_addr)
            `UMTC_OFS_CTRL: begin
                rdata_next[`UMTC_BIT_WR_EN] = wr_en_q;
                rdata_next[`UMTC_BIT_WR_RESET] = wr_busy;
                rdata_next[`UMTC_BIT_RD_EN] = rd_en_q;
                rdata_next[`UMTC_BIT_RD_RESET] = rd_busy;
            end
            `UMTC_OFS_RDREQ: begin
                rdata_next[`UMTC_BIT_REQ] = req_reg;
                rdata_next[`UMTC_BIT_REQ_CLR] = req_clr_reg;
                rdata_next[`UMTC_ADR_HI:`UMTC_ADR_LO] = sel_reg;
            end
            `UMTC_OFS_RDVAL: rdata_next = rdval_reg;
            `UMTC_OFS_INT_STAT: rdata_next[2:0] = int_stat_reg;
            `UMTC_OFS_INT_EN: rdata_next[2:0] = int_en_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    property p_req_done;
        @(posedge ref_clk) disable iff (rst)
        (rd_state_reg == UMTC_DONE && !req_clr_reg) |=> !req_reg && int_stat_reg[`UMTC_INT_REG_RD];
    endproperty
    a_req_done: assert property (p_req_done) else $error("read request not completed");

    property p_req_bound;
        @(posedge ref_clk) disable iff (rst)
        $rose(req_reg) |-> ##[1:4] !req_reg;
    endproperty
    a_req_bound: assert property (p_req_bound) else $error("read request stuck");

    property p_clr_cancels;
        @(posedge ref_clk) disable iff (rst)
        req_clr_reg |=> !req_reg && !req_clr_reg && !int_stat_reg[`UMTC_INT_REG_RD];
    endproperty
    a_clr_cancels: assert property (p_clr_cancels) else $error("clear did not cancel");

    property p_abort_poll;
        @(posedge ref_clk) disable iff (rst)
        (wr_ctrl && reg_wdata[`UMTC_BIT_RD_ABORT]) |-> ##2 !read_dir_enable;
    endproperty
    a_abort_poll: assert property (p_abort_poll) else $error("abort not seen at enable");

    property p_wabort;
        @(posedge ref_clk) disable iff (rst)
        (wr_ctrl && reg_wdata[`UMTC_BIT_WR_ABORT]) |-> ##2 write_dir_abort && !write_dir_enable;
    endproperty
    a_wabort: assert property (p_wabort) else $error("write abort failed");

    property p_zero_write;
        @(posedge ref_clk) disable iff (rst)
        (wr_ctrl && reg_wdata == 32'h00000000 && rd_en_q && !rd_xfer_done) |=> rd_en_q;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write stopped transfer");

    property p_abort_reads_zero;
        @(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == `UMTC_OFS_CTRL) |=> reg_rdata[`UMTC_BIT_RD_ABORT] == 1'b0
            && reg_rdata[`UMTC_BIT_WR_ABORT] == 1'b0;
    endproperty
    a_abort_reads_zero: assert property (p_abort_reads_zero) else $error("abort bit read back");
endmodule

//--- tb/umtc_partner.sv
// far-side model: reports end of master transfers after a set latency
module umtc_partner #(
    parameter logic [31:0] WA = 32'h1111_0048,
    parameter logic [31:0] RA = 32'h2222_0058,
    parameter logic [31:0] TO = 32'h3333_0088
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic read_dir_enable,
    input wire logic write_dir_enable,
    input wire logic [7:0] lat,
    output logic rd_xfer_done,
    output logic wr_xfer_done,
    output logic [31:0] wr_addr_value,
    output logic [31:0] rd_addr_value,
    output logic [31:0] tout_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rd_cnt_reg;
    logic [7:0] wr_cnt_reg;
    assign wr_addr_value = WA;
    assign rd_addr_value = RA;
    assign tout_value = TO;
    // lat of zero stalls forever, so only an abort or a block reset ends the transfer
    always_ff @(posedge ref_clk) begin
        rd_cnt_reg <= (rst || !read_dir_enable) ? 8'h00 : rd_cnt_reg + 8'h01;
        wr_cnt_reg <= (rst || !write_dir_enable) ? 8'h00 : wr_cnt_reg + 8'h01;
    end
    // one pulse only: the counter moves past lat on the next cycle
    always_ff @(posedge ref_clk) begin
        rd_xfer_done <= !rst && read_dir_enable && lat != 8'h00 && rd_cnt_reg == lat;
        wr_xfer_done <= !rst && write_dir_enable && lat != 8'h00 && wr_cnt_reg == lat;
    end
endmodule

//--- tb/usb_master_transfer_control_bench.sv
// self-checking bench for the master transfer control block
`include "umtc_consts.svh"
module usb_master_transfer_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] WA = 32'h1234_5678;
    localparam logic [31:0] RA = 32'h0BAD_F00D;
    localparam logic [31:0] TO = 32'h0000_ABCD;
    logic ref_clk, rst, reg_wr, reg_rd, rd_done, wr_done, rde, wre, rda, wra, rdi, wri, irq;
    logic [5:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v, wav, rav, tov;
    logic [7:0] lat;
    logic [5:0] sel [3];
    logic [31:0] val [3];
    int miscompares, compares, ab_n, in_n, sh;
    umtc_top i_umtc_top (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rd_xfer_done(rd_done), .wr_xfer_done(wr_done), .wr_addr_value(wav),
        .rd_addr_value(rav), .tout_value(tov), .read_dir_enable(rde),
        .write_dir_enable(wre), .read_dir_abort(rda), .write_dir_abort(wra),
        .read_dir_init(rdi), .write_dir_init(wri), .irq(irq));
    umtc_partner #(.WA(WA), .RA(RA), .TO(TO)) i_umtc_partner (.ref_clk(ref_clk),
        .rst(rst), .read_dir_enable(rde), .write_dir_enable(wre), .lat(lat),
        .rd_xfer_done(rd_done), .wr_xfer_done(wr_done), .wr_addr_value(wav),
        .rd_addr_value(rav), .tout_value(tov));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // pulse and init cycles are counted here, checked against totals later
    always @(posedge ref_clk) begin
        if (rda === 1'b1 || wra === 1'b1) ab_n++;
        if (rdi === 1'b1 || wri === 1'b1) in_n++;
    end
    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 32'h0;
        lat = 8'h00;
        sel = '{`UMTC_SEL_WR_ADDR, `UMTC_SEL_RD_ADDR, `UMTC_SEL_TOUT};
        val = '{WA, RA, TO};
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        // all registers clear, the unmapped slot at 0x18 included
        for (int a = 0; a < 7; a++) rchk(6'(a * 4), 32'h0);
        for (int d = 0; d < 2; d++) begin
            sh = d ? 0 : 4;
            wr(`UMTC_OFS_INT_CLR, 32'h7);
            lat <= 8'h00;
            wr(`UMTC_OFS_CTRL, 32'h1 << sh);
            rchk(`UMTC_OFS_CTRL, 32'h1 << sh);
            chk({31'h0, d ? wre : rde}, 32'h1);
            wr(`UMTC_OFS_CTRL, 32'h0);
            rchk(`UMTC_OFS_CTRL, 32'h1 << sh);
            wr(`UMTC_OFS_CTRL, 32'h2 << sh);
            waitc(4);
            rchk(`UMTC_OFS_CTRL, 32'h0);
            chk(32'(ab_n), 32'(d + 1));
            lat <= 8'h06;
            wr(`UMTC_OFS_CTRL, 32'h1 << sh);
            waitc(3);
            for (int i = 0; i < 40 && (d ? wre : rde) !== 1'b0; i++) @(posedge ref_clk);
            rchk(`UMTC_OFS_CTRL, 32'h0);
            rchk(`UMTC_OFS_INT_STAT, 32'h1 << d);
            // transfer already stopped; the endpoint fifo would be re-inited by a core command
            wr(`UMTC_OFS_CTRL, 32'h4 << sh);
            rchk(`UMTC_OFS_CTRL, 32'h4 << sh);
            waitc(8);
            rchk(`UMTC_OFS_CTRL, 32'h0);
            chk(32'(in_n), 32'(4 * (d + 1)));
        end
        // write-done status is still set: enable, mask, then clear
        wr(`UMTC_OFS_INT_EN, 32'h2);
        waitc(2);
        chk({31'h0, irq}, 32'h1);
        wr(`UMTC_OFS_INT_EN, 32'h1);
        waitc(2);
        chk({31'h0, irq}, 32'h0);
        wr(`UMTC_OFS_INT_EN, 32'h7);
        wr(`UMTC_OFS_INT_CLR, 32'h2);
        waitc(2);
        chk({31'h0, irq}, 32'h0);
        rchk(`UMTC_OFS_INT_STAT, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(`UMTC_OFS_RDREQ, 32'h8000_0000 | {24'h0, sel[k], 2'b00});
            rchk(`UMTC_OFS_RDREQ, 32'h8000_0000 | {24'h0, sel[k], 2'b00});
            waitc(4);
            rchk(`UMTC_OFS_RDREQ, {24'h0, sel[k], 2'b00});
            rchk(`UMTC_OFS_RDVAL, val[k]);
            rchk(`UMTC_OFS_INT_STAT, 32'h4);
            wr(`UMTC_OFS_INT_CLR, 32'h4);
        end
        wr(`UMTC_OFS_RDREQ, 32'h8000_0048);
        wr(`UMTC_OFS_RDREQ, 32'h4000_0000);
        waitc(4);
        rd(`UMTC_OFS_RDREQ, v);
        chk(v & 32'hC000_0000, 32'h0);
        rchk(`UMTC_OFS_INT_STAT, 32'h0);
        // a cancelled fetch must not overwrite the last stored value
        rchk(`UMTC_OFS_RDVAL, TO);
        end_of_test();
    end
endmodule
